/* File: verilog/idw_pkg.sv */
// Package for the identify parameter word bank (words 51 to 79).
// Assumes an 8-bit word index bus from the identify command engine.
package idw_pkg;

    // Word indices of the bank
    localparam logic [7:0] IDW_LEGACY_PIO   = 8'h33;
    localparam logic [7:0] IDW_VALIDITY     = 8'h35;
    localparam logic [7:0] IDW_CUR_CYL      = 8'h36;
    localparam logic [7:0] IDW_CUR_HEADS    = 8'h37;
    localparam logic [7:0] IDW_CUR_SECT     = 8'h38;
    localparam logic [7:0] IDW_CAP_LO       = 8'h39;
    localparam logic [7:0] IDW_CAP_HI       = 8'h3a;
    localparam logic [7:0] IDW_MULT_SECT    = 8'h3b;
    localparam logic [7:0] IDW_LBA_LO       = 8'h3c;
    localparam logic [7:0] IDW_LBA_HI       = 8'h3d;
    localparam logic [7:0] IDW_MDMA         = 8'h3f;
    localparam logic [7:0] IDW_ADV_PIO      = 8'h40;
    localparam logic [7:0] IDW_MIN_DMA      = 8'h41;
    localparam logic [7:0] IDW_REC_DMA      = 8'h42;
    localparam logic [7:0] IDW_PIO_NOFLOW   = 8'h43;
    localparam logic [7:0] IDW_PIO_FLOW     = 8'h44;
    localparam logic [7:0] IDW_SER_CAP      = 8'h4c;
    localparam logic [7:0] IDW_SER_SUP      = 8'h4e;
    localparam logic [7:0] IDW_SER_ENA      = 8'h4f;

    // Fixed field values
    localparam logic [7:0]  IDW_LEGACY_PIO_MODE = 8'h02;
    localparam logic [15:0] IDW_VALID_BITS      = 16'h0007;
    localparam int          IDW_MULT_VALID_BIT  = 8;
    localparam logic [7:0]  IDW_MDMA_SEL_RST    = 8'h00;
    localparam logic [7:0]  IDW_MULT_RST        = 8'h00;
    localparam logic [5:0]  IDW_FEAT_ENA_RST    = 6'h00;

    // Static configuration straps of the drive
    typedef struct packed {
        logic [15:0] cylinders;
        logic [15:0] heads;
        logic [15:0] sectors;
        logic [31:0] lba_total;
        logic [2:0]  mdma_support;
        logic [1:0]  pio_adv;
        logic [15:0] min_dma_ns;
        logic [15:0] rec_dma_ns;
        logic [15:0] pio_noflow_ns;
        logic [15:0] pio_flow_ns;
        logic [2:0]  ser_cap_hi;
        logic [1:0]  ser_speed;
        logic [5:0]  feat_support;
    } idw_cfg_t;

    // Host setting commands
    typedef struct packed {
        logic       set_mult;
        logic [7:0] mult_count;
        logic       set_mdma;
        logic [1:0] mdma_mode;
        logic       clr_mdma;
        logic       set_feat;
        logic [5:0] feat_mask;
        logic       feat_on;
    } idw_cmd_t;

endpackage

/* File: verilog/idw_bank.sv */
// Identify parameter words 51 to 79 as a read-only word bank.
// Assumes cfg is static while out of reset; commands are one-cycle pulses.
//
// Function
// - Word 51 high byte reads 02h
// - Word 53 bits 0,1,2 flag valid groups
// - Current geometry words; capacity is the low 32 bits of their product
// - Word 59: bit 8 set, low byte 00h/01h
// - Words 60-61 give total LBA sectors
// - Word 63 high byte one-hot selected mode
// - Word 63 low byte lists supported modes
// - DMA fields supported sets word 53 bit 1
// - Word 64 bits 1,0 flag PIO 4,3
// - Word 65 minimum DMA cycle, not below fastest
// - Word 66 recommended, never below word 65
// - Word 67 no-flow PIO time, not below 68
// - Word 68 equals fastest PIO mode time
// - Unsupported cycle-time fields read zero
// - Word 76 serial capability bits, bit 0 zero
// - Word 78 feature support bits, bit 0 zero
// - Word 79 enabled bits mirror support layout
`timescale 1ns/1ps
`default_nettype none

module idw_bank
    import idw_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Drive configuration
    input  wire idw_cfg_t    cfg,
    // Setting commands from the command decoder
    input  wire idw_cmd_t    cmd,
    // Word read port
    input  wire logic        rd_en,
    input  wire logic [7:0]  rd_index,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic             rd_hit
);

    ////////////////////////////////////////////////////////////////////////
    // Host-settable state

    logic [7:0] mult_count;
    logic [7:0] mdma_sel;
    logic [5:0] feat_ena;

    // Multiple count only accepts 00h or 01h, else the old value stands
    wire mult_ok = cmd.set_mult && (cmd.mult_count[7:1] == 7'h00);

    // One-hot select of a supported mode only; mode 3 code is refused.
    // A support bit also covers every slower mode below it, so mode k
    // counts as supported when any support bit at k or above is set.
    wire [2:0] mdma_onehot = 3'b001 << cmd.mdma_mode;
    wire [2:0] mdma_reach  = cfg.mdma_support >> cmd.mdma_mode;
    wire mdma_ok = cmd.set_mdma && (cmd.mdma_mode != 2'd3)
                   && (mdma_reach != 3'b000);

    // Only supported features may be enabled
    wire [5:0] next_feat = cmd.feat_on ? (feat_ena | cmd.feat_mask)
                                       : (feat_ena & ~cmd.feat_mask);

    // Settings change only on a setting command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mult_count <= IDW_MULT_RST;
            mdma_sel   <= IDW_MDMA_SEL_RST;
            feat_ena   <= IDW_FEAT_ENA_RST;
        end else begin
            if (mult_ok)
                mult_count <= cmd.mult_count;
            if (cmd.clr_mdma)
                mdma_sel <= 8'h00;
            else if (mdma_ok)
                mdma_sel <= {5'h00, mdma_onehot};
            if (cmd.set_feat)
                feat_ena <= next_feat & cfg.feat_support;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Derived word values

    // Product of current geometry; upper bits beyond 32 are dropped
    wire [47:0] cap_full = cfg.cylinders * cfg.heads * cfg.sectors;
    wire [31:0] capacity = cap_full[31:0];

    // Supported modes: bit 2 implies modes 1 and 0 as well
    wire [7:0] mdma_sup = {5'h00, cfg.mdma_support};
    wire       dma_sup  = (cfg.mdma_support != 3'b000);
    wire       pio_sup  = (cfg.pio_adv != 2'b00);
    wire       grp2_ok  = dma_sup || pio_sup;

    // Cycle-time fields read zero when not supported
    wire [15:0] min_dma = dma_sup ? cfg.min_dma_ns : 16'h0000;
    // Recommended never reported below the minimum
    wire [15:0] rec_dma = !dma_sup ? 16'h0000
                        : (cfg.rec_dma_ns < cfg.min_dma_ns) ? cfg.min_dma_ns
                        : cfg.rec_dma_ns;
    wire [15:0] pio_flow   = pio_sup ? cfg.pio_flow_ns : 16'h0000;
    // No-flow time is clamped up to the flow-control time
    wire [15:0] pio_noflow = !pio_sup ? 16'h0000
                        : (cfg.pio_noflow_ns < cfg.pio_flow_ns)
                          ? cfg.pio_flow_ns : cfg.pio_noflow_ns;

    // Validity word: bit 1 follows any supported timing field
    wire [15:0] validity = {13'h0000, IDW_VALID_BITS[2], grp2_ok,
                            IDW_VALID_BITS[0]};

    ////////////////////////////////////////////////////////////////////////
    // Word values, reserved bits zero-filled throughout

    // Each mapped word exactly as the host will see it
    wire [15:0] w_legacy_pio = {IDW_LEGACY_PIO_MODE, 8'h00};
    wire [15:0] w_validity   = validity;
    wire [15:0] w_cur_cyl    = cfg.cylinders;
    wire [15:0] w_cur_heads  = cfg.heads;
    wire [15:0] w_cur_sect   = cfg.sectors;
    wire [15:0] w_cap_lo     = capacity[15:0];
    wire [15:0] w_cap_hi     = capacity[31:16];
    // Bit 8 marks the multiple setting valid; bits 15 to 9 stay zero
    wire [15:0] w_mult_sect  = (16'h0001 << IDW_MULT_VALID_BIT)
                             | {8'h00, mult_count};
    wire [15:0] w_lba_lo     = cfg.lba_total[15:0];
    wire [15:0] w_lba_hi     = cfg.lba_total[31:16];
    wire [15:0] w_mdma       = {mdma_sel, mdma_sup};
    wire [15:0] w_adv_pio    = {14'h0000, cfg.pio_adv};
    wire [15:0] w_min_dma    = min_dma;
    wire [15:0] w_rec_dma    = rec_dma;
    wire [15:0] w_pio_noflow = pio_noflow;
    wire [15:0] w_pio_flow   = pio_flow;
    wire [15:0] w_ser_cap    = {5'h00, cfg.ser_cap_hi, 5'h00,
                                cfg.ser_speed, 1'b0};
    wire [15:0] w_ser_sup    = {9'h000, cfg.feat_support, 1'b0};
    wire [15:0] w_ser_ena    = {9'h000, feat_ena, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // Index decode, one slot per mapped word

    // Gated words and match flags; a slot that misses leaves both zero
    wire [18:0][15:0] gated;
    wire [18:0]       hits;

    idw_word_slot #(
        .INDEX (IDW_LEGACY_PIO),
        .WIDTH (16)
    ) i_slot_legacy_pio (
        .rd_index (rd_index),
        .value    (w_legacy_pio),
        .gated    (gated[0]),
        .hit      (hits[0])
    );

    idw_word_slot #(
        .INDEX (IDW_VALIDITY),
        .WIDTH (16)
    ) i_slot_validity (
        .rd_index (rd_index),
        .value    (w_validity),
        .gated    (gated[1]),
        .hit      (hits[1])
    );

    idw_word_slot #(
        .INDEX (IDW_CUR_CYL),
        .WIDTH (16)
    ) i_slot_cur_cyl (
        .rd_index (rd_index),
        .value    (w_cur_cyl),
        .gated    (gated[2]),
        .hit      (hits[2])
    );

    idw_word_slot #(
        .INDEX (IDW_CUR_HEADS),
        .WIDTH (16)
    ) i_slot_cur_heads (
        .rd_index (rd_index),
        .value    (w_cur_heads),
        .gated    (gated[3]),
        .hit      (hits[3])
    );

    idw_word_slot #(
        .INDEX (IDW_CUR_SECT),
        .WIDTH (16)
    ) i_slot_cur_sect (
        .rd_index (rd_index),
        .value    (w_cur_sect),
        .gated    (gated[4]),
        .hit      (hits[4])
    );

    idw_word_slot #(
        .INDEX (IDW_CAP_LO),
        .WIDTH (16)
    ) i_slot_cap_lo (
        .rd_index (rd_index),
        .value    (w_cap_lo),
        .gated    (gated[5]),
        .hit      (hits[5])
    );

    idw_word_slot #(
        .INDEX (IDW_CAP_HI),
        .WIDTH (16)
    ) i_slot_cap_hi (
        .rd_index (rd_index),
        .value    (w_cap_hi),
        .gated    (gated[6]),
        .hit      (hits[6])
    );

    idw_word_slot #(
        .INDEX (IDW_MULT_SECT),
        .WIDTH (16)
    ) i_slot_mult_sect (
        .rd_index (rd_index),
        .value    (w_mult_sect),
        .gated    (gated[7]),
        .hit      (hits[7])
    );

    idw_word_slot #(
        .INDEX (IDW_LBA_LO),
        .WIDTH (16)
    ) i_slot_lba_lo (
        .rd_index (rd_index),
        .value    (w_lba_lo),
        .gated    (gated[8]),
        .hit      (hits[8])
    );

    idw_word_slot #(
        .INDEX (IDW_LBA_HI),
        .WIDTH (16)
    ) i_slot_lba_hi (
        .rd_index (rd_index),
        .value    (w_lba_hi),
        .gated    (gated[9]),
        .hit      (hits[9])
    );

    idw_word_slot #(
        .INDEX (IDW_MDMA),
        .WIDTH (16)
    ) i_slot_mdma (
        .rd_index (rd_index),
        .value    (w_mdma),
        .gated    (gated[10]),
        .hit      (hits[10])
    );

    idw_word_slot #(
        .INDEX (IDW_ADV_PIO),
        .WIDTH (16)
    ) i_slot_adv_pio (
        .rd_index (rd_index),
        .value    (w_adv_pio),
        .gated    (gated[11]),
        .hit      (hits[11])
    );

    idw_word_slot #(
        .INDEX (IDW_MIN_DMA),
        .WIDTH (16)
    ) i_slot_min_dma (
        .rd_index (rd_index),
        .value    (w_min_dma),
        .gated    (gated[12]),
        .hit      (hits[12])
    );

    idw_word_slot #(
        .INDEX (IDW_REC_DMA),
        .WIDTH (16)
    ) i_slot_rec_dma (
        .rd_index (rd_index),
        .value    (w_rec_dma),
        .gated    (gated[13]),
        .hit      (hits[13])
    );

    idw_word_slot #(
        .INDEX (IDW_PIO_NOFLOW),
        .WIDTH (16)
    ) i_slot_pio_noflow (
        .rd_index (rd_index),
        .value    (w_pio_noflow),
        .gated    (gated[14]),
        .hit      (hits[14])
    );

    idw_word_slot #(
        .INDEX (IDW_PIO_FLOW),
        .WIDTH (16)
    ) i_slot_pio_flow (
        .rd_index (rd_index),
        .value    (w_pio_flow),
        .gated    (gated[15]),
        .hit      (hits[15])
    );

    idw_word_slot #(
        .INDEX (IDW_SER_CAP),
        .WIDTH (16)
    ) i_slot_ser_cap (
        .rd_index (rd_index),
        .value    (w_ser_cap),
        .gated    (gated[16]),
        .hit      (hits[16])
    );

    idw_word_slot #(
        .INDEX (IDW_SER_SUP),
        .WIDTH (16)
    ) i_slot_ser_sup (
        .rd_index (rd_index),
        .value    (w_ser_sup),
        .gated    (gated[17]),
        .hit      (hits[17])
    );

    idw_word_slot #(
        .INDEX (IDW_SER_ENA),
        .WIDTH (16)
    ) i_slot_ser_ena (
        .rd_index (rd_index),
        .value    (w_ser_ena),
        .gated    (gated[18]),
        .hit      (hits[18])
    );

    ////////////////////////////////////////////////////////////////////////
    // Word selection

    logic [15:0] word_mux;
    logic        word_hit;

    // At most one slot hits, so an OR of the gated words selects it;
    // an unmapped index leaves every slot dark and reads zero
    assign word_mux = gated[0]  | gated[1]  | gated[2]  | gated[3]
                    | gated[4]  | gated[5]  | gated[6]  | gated[7]
                    | gated[8]  | gated[9]  | gated[10] | gated[11]
                    | gated[12] | gated[13] | gated[14] | gated[15]
                    | gated[16] | gated[17] | gated[18];
    assign word_hit = |hits;

    ////////////////////////////////////////////////////////////////////////
    // Registered read answer, one cycle after rd_en

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
            rd_hit   <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            rd_data  <= rd_en ? word_mux : 16'h0000;
            rd_hit   <= rd_en && word_hit;
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////
// One word slot: matches the read index and gates its word onto an OR bus

module idw_word_slot #(
    parameter logic [7:0] INDEX = 8'h00,
    parameter int         WIDTH = 16
) (
    // Read index from the host side
    input  wire logic [7:0]       rd_index,
    // Word presented by this slot
    input  wire logic [WIDTH-1:0] value,
    // Gated word and match flag
    output logic      [WIDTH-1:0] gated,
    output logic                  hit
);

    // A miss drives zeros, which is what lets the slots be ORed together
    assign hit   = (rd_index == INDEX);
    assign gated = hit ? value : '0;

endmodule

`default_nettype wire

/* File: dv/idw_monitor.sv */
// Port checker for the identify word bank.
// Assumes cfg is held static while out of reset.
`timescale 1ns/1ps
`default_nettype none
module idw_monitor
    import idw_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Watched ports
    input  wire idw_cfg_t    cfg,
    input  wire idw_cmd_t    cmd,
    input  wire logic        rd_en,
    input  wire logic [7:0]  rd_index,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        rd_hit
);
    // Full geometry product; the bank reports its low 32 bits
    wire logic [47:0] geo = cfg.cylinders * cfg.heads * cfg.sectors;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // A read of word i taken now shows q in the answer cycle
    property wd(logic [7:0] i, untyped q);
        rd_en && rd_index == i |=> q;
    endproperty
    legacy_pio_a: assert property (
        wd(IDW_LEGACY_PIO, rd_data[15:8] == 8'h02)) else $error("word 51");
    valid_flags_a: assert property (wd(IDW_VALIDITY,
        rd_data == {13'h0, 1'b1, (|cfg.mdma_support) || (|cfg.pio_adv),
        1'b1})) else $error("word 53");
    capacity_lo_a: assert property (
        wd(IDW_CAP_LO, rd_data == geo[15:0])) else $error("word 57");
    mult_setting_a: assert property (
        wd(IDW_MULT_SECT, rd_data[15:1] == 15'h0080)) else $error("word 59");
    lba_low_a: assert property (
        wd(IDW_LBA_LO, rd_data == cfg.lba_total[15:0])) else $error("word 60");
    mdma_fields_a: assert property (wd(IDW_MDMA,
        $onehot0(rd_data[15:8]) && rd_data[15:11] == 5'h00
        && rd_data[7:0] == {5'h00, cfg.mdma_support})) else $error("word 63");
    adv_pio_a: assert property (
        wd(IDW_ADV_PIO, rd_data == {14'h0, cfg.pio_adv})) else $error("word 64");
    rec_dma_a: assert property (wd(IDW_REC_DMA,
        rd_data >= cfg.min_dma_ns || cfg.mdma_support == 3'h0))
        else $error("word 66");
    pio_noflow_a: assert property (wd(IDW_PIO_NOFLOW,
        rd_data >= cfg.pio_flow_ns || cfg.pio_adv == 2'h0))
        else $error("word 67");
    ser_cap_a: assert property (wd(IDW_SER_CAP, rd_data ==
        {5'h00, cfg.ser_cap_hi, 5'h00, cfg.ser_speed, 1'b0}))
        else $error("word 76");
    feat_ena_a: assert property (wd(IDW_SER_ENA,
        rd_data[15:7] == 9'h000 && !rd_data[0]
        && (rd_data[6:1] & ~cfg.feat_support) == 6'h00)) else $error("word 79");
    capacity_hi_a: assert property (
        wd(IDW_CAP_HI, rd_data == geo[31:16])) else $error("word 58");
    min_dma_a: assert property (wd(IDW_MIN_DMA,
        rd_data == (cfg.mdma_support == 3'h0 ? 16'h0 : cfg.min_dma_ns)))
        else $error("word 65");
    pio_flow_a: assert property (wd(IDW_PIO_FLOW,
        rd_data == (cfg.pio_adv == 2'h0 ? 16'h0 : cfg.pio_flow_ns)))
        else $error("word 68");
    feat_sup_a: assert property (wd(IDW_SER_SUP,
        rd_data == {9'h000, cfg.feat_support, 1'b0})) else $error("word 78");
    unmapped_a: assert property (
        rd_en && (rd_index < IDW_LEGACY_PIO || rd_index > IDW_SER_ENA)
        |=> !rd_hit && rd_data == 16'h0000) else $error("unmapped word");
    // Main scenarios: mode 2 selected, count 1 set, a feature enabled
    cover property (rd_en && rd_index == IDW_MDMA ##1 rd_data[10]);
    cover property (rd_en && rd_index == IDW_MULT_SECT ##1 rd_data[0]);
    cover property (rd_en && rd_index == IDW_SER_ENA ##1 rd_data[3]);
endmodule
`default_nettype wire

/* File: dv/idw_host.sv */
// Host model: issues word reads and setting commands to the bank.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module idw_host
    import idw_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Bank side
    output var idw_cmd_t     cmd,
    output logic             rd_en,
    output logic [7:0]       rd_index,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        rd_hit
);
    // Idle bus at time zero
    initial begin
        cmd = '0;
        rd_en = 1'b0;
        rd_index = 8'h00;
    end
    // Read one word; the answer stands only one cycle, so sample it there
    task automatic get(input logic [7:0] ix, output logic [15:0] d,
                       output logic h, output logic v);
        rd_en <= 1'b1;
        rd_index <= ix;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rd_data;
        h = rd_hit;
        v = rd_valid;
        @(posedge clk);
    endtask
    // One-cycle command pulse, then a quiet edge
    task automatic send(input idw_cmd_t c);
        cmd <= c;
        @(posedge clk);
        cmd <= '0;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: dv/identify_param_words_test.sv */
// Bench for the identify word bank: straps, table read-back, commands.
// Assumes idw_bank, the host model idw_host and the checker idw_monitor.
`timescale 1ns/1ps
`default_nettype none
module identify_param_words_test
    import idw_pkg::*;
;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        rd_en, rd_valid, rd_hit;
    logic [7:0]  rd_index;
    logic [15:0] rd_data;
    idw_cmd_t    cmd;
    int          fail_count = 0;
    int          checked = 0;
    // Words 66 and 67 are strapped low on purpose to check clamping
    idw_cfg_t cfg = '{16'h3fff, 16'h0010, 16'h003f, 32'h00fbfc10, 3'h7,
        2'h3, 16'h0078, 16'h0070, 16'h0064, 16'h0078, 3'h5, 2'h3, 6'h04};
    // Index and expected word; the last three are unmapped
    logic [7:0] ixs [22] = '{8'h33, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39,
        8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43,
        8'h44, 8'h4c, 8'h4e, 8'h4f, 8'h00, 8'h3e, 8'h50};
    logic [15:0] exs [22] = '{16'h0200, 16'h0007, 16'h3fff, 16'h0010,
        16'h003f, 16'hfc10, 16'h00fb, 16'h0100, 16'hfc10, 16'h00fb,
        16'h0007, 16'h0003, 16'h0078, 16'h0078, 16'h0078, 16'h0078,
        16'h0506, 16'h0008, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    idw_bank i_idw_bank (.clk(clk), .arst_n(arst_n), .cfg(cfg), .cmd(cmd),
        .rd_en(rd_en), .rd_index(rd_index), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_hit(rd_hit));
    idw_host i_idw_host (.clk(clk), .cmd(cmd), .rd_en(rd_en),
        .rd_index(rd_index), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_hit(rd_hit));
    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Read a word and compare data, hit and the answer strobe
    task automatic rd_chk(input logic [7:0] ix, input logic [15:0] e,
                          input logic eh);
        logic [15:0] g;
        logic        h, v;
        i_idw_host.get(ix, g, h, v);
        chk($sformatf("word %h", ix), e, g);
        chk("hit", {15'h0, eh}, {15'h0, h});
        chk("valid", 16'h0001, {15'h0, v});
    endtask
    task automatic cmd_chk(input idw_cmd_t c, input logic [7:0] ix,
                           input logic [15:0] e);
        i_idw_host.send(c);
        rd_chk(ix, e, 1'b1);
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Reset, read-back, refused and accepted commands, mid-run reset
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 22; k++) begin
            rd_chk(ixs[k], exs[k], k < 19);
        end
        cmd_chk('{set_mult: 1'b1, mult_count: 8'h01, default: '0},
            IDW_MULT_SECT, 16'h0101);
        cmd_chk('{set_mult: 1'b1, mult_count: 8'h02, default: '0},
            IDW_MULT_SECT, 16'h0101);
        for (int m = 0; m < 4; m++) begin
            cmd_chk('{set_mdma: 1'b1, mdma_mode: 2'(m), default: '0}, IDW_MDMA,
                16'h0007 | (16'h0100 << (m < 3 ? m : 2)));
        end
        cmd_chk('{clr_mdma: 1'b1, default: '0}, IDW_MDMA, 16'h0007);
        cmd_chk('{set_feat: 1'b1, feat_mask: 6'h3f, feat_on: 1'b1,
            default: '0}, IDW_SER_ENA, 16'h0008);
        cmd_chk('{set_feat: 1'b1, feat_mask: 6'h3f, default: '0},
            IDW_SER_ENA, 16'h0000);
        arst_n <= 1'b0;
        // Only the mode 2 support bit: the slower mode 0 must still be admitted
        cfg.mdma_support <= 3'b100;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_chk(IDW_MULT_SECT, 16'h0100, 1'b1);
        rd_chk(IDW_MDMA, 16'h0004, 1'b1);
        cmd_chk('{set_mdma: 1'b1, mdma_mode: 2'd0, default: '0},
            IDW_MDMA, 16'h0104);
        close_out;
    end
endmodule
bind idw_bank idw_monitor i_idw_monitor (.clk(clk), .arst_n(arst_n),
    .cfg(cfg), .cmd(cmd), .rd_en(rd_en), .rd_index(rd_index),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));
`default_nettype wire
